// File: i2csw_top.sv
`timescale 1ns/100ps
module i2csw_top import i2csw_pkg::*; #(
  parameter logic [4:0] DEV_ADDR_HI = DEV_ADDR_HI_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic reset_in_n,
  input wire logic [NUM_CHAN-1:0] channel_irq_in_n,
  input wire logic [1:0] addr_sel,
  output logic irq_out,
  output logic irq_oe_n,
  output logic [NUM_CHAN-1:0] channel_enable
);
  localparam logic [4:0] HOLD_LIM = 5'(SDA_HOLD_CYC);

  i2csw_sig_if sig ();

  // Pin conditioning and interrupt pulse rejection
  i2csw_sync u_sync (
    .clk(clk),
    .rst(rst),
    .raw({addr_sel, channel_irq_in_n, sda_in, scl_in}),
    .sig(sig.sync_mp)
  );

  i2csw_irq_filt u_filt (
    .clk(clk),
    .rst(rst),
    .sig(sig.filt_mp)
  );

  // ---- Link side: SDA shifted on the master's own SCL edges ----
  logic [7:0] link_shift;
  logic [7:0] next_link_shift;

  // The word crosses to the system clock without a handshake: it is
  // read only at the conditioned SCL rise, some cycles after the edge
  // that loaded it, and stays still for the whole SCL high and low time
  // Data only; SCL stops between frames, so no state depends on it
  always_comb begin
    next_link_shift = {link_shift[6:0], sda_in};
  end

  always_ff @(posedge scl_clk) begin
    link_shift <= next_link_shift;
  end

  // ---- Reset pin catcher ----
  // The pin pulse may be as short as 6 ns, far below one clock period,
  // so it sets a flag asynchronously and the flag is synchronised.
  logic rst_catch;
  logic next_rst_catch;
  logic rst_s1;
  logic rst_s2;
  logic next_rst_s1;
  logic next_rst_s2;
  logic soft_rst;

  // The catch clears itself once the synchronised copy has seen it,
  // unless the pin is still low, which holds it through the async path
  always_comb begin
    next_rst_catch = rst_catch & ~rst_s2;
    next_rst_s1 = rst_catch;
    next_rst_s2 = rst_s1;
  end

  always_ff @(posedge clk or negedge reset_in_n) begin
    if (!reset_in_n) begin
      rst_catch <= 1'b1;
    end else if (rst) begin
      rst_catch <= 1'b0;
    end else begin
      rst_catch <= next_rst_catch;
    end
  end

  // Two-stage synchroniser for the caught reset
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= next_rst_s1;
      rst_s2 <= next_rst_s2;
    end
  end

  assign soft_rst = rst_s2;

  // ---- Protocol engine ----
  i2csw_state_type state;
  i2csw_state_type next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic rw;
  logic next_rw;
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [4:0] hold;
  logic [4:0] next_hold;
  logic next_sda_oe_n;
  logic scl_prev;
  logic sda_prev;
  logic scl_c;
  logic sda_c;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic next_irq_oe_n;

  // High when the device pulls SDA low in this state and bit slot
  function automatic logic drive_low(input i2csw_state_type st, input logic [2:0] idx,
                                     input logic [7:0] byte_out);
    case (st)
      I2CSW_ADDR_ACK: drive_low = 1'b1;
      I2CSW_WR_ACK: drive_low = 1'b1;
      I2CSW_RD_DATA: drive_low = ~byte_out[BIT_LAST - idx];
      default: drive_low = 1'b0;
    endcase
  endfunction : drive_low

  // Bus events from the conditioned pins; both share the same delay
  always_comb begin
    scl_c = sig.clean[SYNC_SCL];
    sda_c = sig.clean[SYNC_SDA];
    scl_rise = scl_c & ~scl_prev;
    scl_fall = ~scl_c & scl_prev;
    start_cond = scl_c & scl_prev & sda_prev & ~sda_c;
    stop_cond = scl_c & scl_prev & ~sda_prev & sda_c;
  end

  // Next state of the engine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_rw = rw;
    next_ctrl = ctrl;
    next_tx = tx;
    next_hold = hold;
    next_sda_oe_n = sda_oe_n;

    // Own SDA changes only after the hold time past SCL fall
    // Counting from the conditioned edge adds the synchroniser delay, so
    // the real hold is a few cycles longer, well inside the valid limit
    if (scl_fall) begin
      next_hold = 5'h01;
    end else if (hold != 5'h00) begin
      if (hold >= HOLD_LIM) begin
        next_hold = 5'h00;
        next_sda_oe_n = ~drive_low(state, bit_cnt, tx);
      end else begin
        next_hold = hold + 5'h01;
      end
    end

    // Byte words come from the link shifter, stable until the next rise
    if (scl_rise) begin
      case (state)
        I2CSW_ADDR: begin
          if (bit_cnt == BIT_LAST) begin
            next_bit_cnt = 3'h0;
            if (link_shift[7:1] == {DEV_ADDR_HI, sig.clean[SYNC_ADDR_LSB +: 2]}) begin
              next_rw = link_shift[0];
              next_state = I2CSW_ADDR_ACK;
            end else begin
              next_state = I2CSW_IGNORE;
            end
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        I2CSW_ADDR_ACK: begin
          next_bit_cnt = 3'h0;
          if (rw) begin
            next_state = I2CSW_RD_DATA;
            next_tx = {sig.irq_act, ctrl};
          end else begin
            next_state = I2CSW_WR_DATA;
          end
        end
        I2CSW_WR_DATA: begin
          if (bit_cnt == BIT_LAST) begin
            next_ctrl = link_shift[3:0];
            next_bit_cnt = 3'h0;
            next_state = I2CSW_WR_ACK;
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        I2CSW_WR_ACK: begin
          next_state = I2CSW_WR_DATA;
        end
        I2CSW_RD_DATA: begin
          if (bit_cnt == BIT_LAST) begin
            next_bit_cnt = 3'h0;
            next_state = I2CSW_RD_ACK;
          end else begin
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        I2CSW_RD_ACK: begin
          // Master NACK ends the read; ACK re-sends the register
          if (sda_c) begin
            next_state = I2CSW_IGNORE;
          end else begin
            next_state = I2CSW_RD_DATA;
            next_tx = {sig.irq_act, ctrl};
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end

    // Start wins over stop; either frees the data line
    // A repeated start in mid-byte simply restarts address collection
    if (start_cond) begin
      next_state = I2CSW_ADDR;
      next_bit_cnt = 3'h0;
      next_hold = 5'h00;
      next_sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      next_state = I2CSW_IDLE;
      next_hold = 5'h00;
      next_sda_oe_n = 1'b1;
    end

    // Pin reset clears the engine and control register, but leaves the edge trackers and interrupt filter live
    // so a start right after release is still seen
    if (soft_rst) begin
      next_state = I2CSW_IDLE;
      next_bit_cnt = 3'h0;
      next_rw = 1'b0;
      next_ctrl = CTRL_RST_VAL;
      next_tx = BYTE_RST_VAL;
      next_hold = 5'h00;
      next_sda_oe_n = 1'b1;
    end
  end

  // Combined interrupt: any filtered channel pulls the line low
  always_comb begin
    next_irq_oe_n = ~(|sig.irq_act);
  end

  // Both pin values stay zero: the lines are open drain and only the
  // enables move
  // Register engine and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= I2CSW_IDLE;
      bit_cnt <= 3'h0;
      rw <= 1'b0;
      ctrl <= CTRL_RST_VAL;
      tx <= BYTE_RST_VAL;
      hold <= 5'h00;
      sda_oe_n <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      irq_oe_n <= 1'b1;
      sda_out <= 1'b0;
      irq_out <= 1'b0;
      channel_enable <= CTRL_RST_VAL;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      rw <= next_rw;
      ctrl <= next_ctrl;
      tx <= next_tx;
      hold <= next_hold;
      sda_oe_n <= next_sda_oe_n;
      scl_prev <= scl_c;
      sda_prev <= sda_c;
      irq_oe_n <= next_irq_oe_n;
      sda_out <= 1'b0;
      irq_out <= 1'b0;
      channel_enable <= next_ctrl;
    end
  end

endmodule : i2csw_top

// File: i2csw_pkg.sv
package i2csw_pkg;

  // Pin timing figures
  localparam int CLK_PERIOD_NS = 20;
  localparam int IRQ_LOW_REJ_NS = 1000;
  localparam int IRQ_HIGH_REJ_NS = 500;
  localparam int SDA_HOLD_NS = 300;
  localparam int RST_SDA_MAX_NS = 500;

  // Least times round up to whole cycles, never below one
  function automatic int i2csw_ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : i2csw_ceil_cyc

  localparam int IRQ_LOW_REJ_CYC = i2csw_ceil_cyc(IRQ_LOW_REJ_NS);
  localparam int IRQ_HIGH_REJ_CYC = i2csw_ceil_cyc(IRQ_HIGH_REJ_NS);
  localparam int SDA_HOLD_CYC = i2csw_ceil_cyc(SDA_HOLD_NS);
  // Longest time rounds down; the reset path is far shorter than this
  localparam int RST_SDA_MAX_CYC = RST_SDA_MAX_NS / CLK_PERIOD_NS;

  // Layout of the synchronised pin vector
  localparam int NUM_CHAN = 4;
  localparam int SYNC_W = 8;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_IRQ_LSB = 2;
  localparam int SYNC_ADDR_LSB = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 8'hFF;

  // Control register: low nibble enables, high nibble interrupt view
  localparam logic [3:0] CTRL_RST_VAL = 4'h0;
  localparam logic [7:0] BYTE_RST_VAL = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [4:0] DEV_ADDR_HI_DEF = 5'h15;

  typedef enum logic [2:0] {
    I2CSW_IDLE     = 3'b000,
    I2CSW_ADDR     = 3'b001,
    I2CSW_ADDR_ACK = 3'b010,
    I2CSW_WR_DATA  = 3'b011,
    I2CSW_WR_ACK   = 3'b100,
    I2CSW_RD_DATA  = 3'b101,
    I2CSW_RD_ACK   = 3'b110,
    I2CSW_IGNORE   = 3'b111
  } i2csw_state_type;

endpackage : i2csw_pkg

// File: i2csw_sig_if.sv
`timescale 1ns/100ps
interface i2csw_sig_if import i2csw_pkg::*; ();
  logic [SYNC_W-1:0] clean;
  logic [NUM_CHAN-1:0] irq_act;

  modport sync_mp (output clean);
  modport filt_mp (input clean, output irq_act);
  modport core_mp (input clean, input irq_act);
endinterface : i2csw_sig_if

// File: i2csw_sync.sv
`timescale 1ns/100ps
module i2csw_sync import i2csw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SYNC_W-1:0] raw,
  i2csw_sig_if.sync_mp sig
);
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] clean;
  logic [SYNC_W-1:0] next_clean;
  logic [SYNC_W-1:0] agree;

  // A change counts only once stages two and three agree
  always_comb begin
    agree = ~(s2 ^ s3);
    next_clean = (s3 & agree) | (clean & ~agree);
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= SYNC_RST_VAL;
      s2 <= SYNC_RST_VAL;
      s3 <= SYNC_RST_VAL;
      clean <= SYNC_RST_VAL;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      clean <= next_clean;
    end
  end

  assign sig.clean = clean;
endmodule : i2csw_sync

// File: i2csw_irq_filt.sv
`timescale 1ns/100ps
module i2csw_irq_filt import i2csw_pkg::*; #(
  parameter int LOW_REJ = IRQ_LOW_REJ_CYC,
  parameter int HIGH_REJ = IRQ_HIGH_REJ_CYC
) (
  input wire logic clk,
  input wire logic rst,
  i2csw_sig_if.filt_mp sig
);
  localparam logic [6:0] LOW_LIM = 7'(LOW_REJ);
  localparam logic [6:0] HIGH_LIM = 7'(HIGH_REJ);

  logic [NUM_CHAN-1:0] act;
  logic [NUM_CHAN-1:0] next_act;
  logic [6:0] cnt [NUM_CHAN];
  logic [6:0] next_cnt [NUM_CHAN];
  logic [NUM_CHAN-1:0] req;

  // A new level must persist for the whole reject time to be taken;
  // shorter pulses restart the count and never reach the output
  always_comb begin
    req = ~sig.clean[SYNC_IRQ_LSB +: NUM_CHAN];
    next_act = act;
    for (int i = 0; i < NUM_CHAN; i++) begin
      next_cnt[i] = 7'h00;
      if (req[i] != act[i]) begin
        next_cnt[i] = cnt[i] + 7'h01;
        if (req[i] && (cnt[i] + 7'h01 >= LOW_LIM)) begin
          next_act[i] = 1'b1;
          next_cnt[i] = 7'h00;
        end
        if (!req[i] && (cnt[i] + 7'h01 >= HIGH_LIM)) begin
          next_act[i] = 1'b0;
          next_cnt[i] = 7'h00;
        end
      end
    end
  end

  // Register filter state
  always_ff @(posedge clk) begin
    if (rst) begin
      act <= '0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        cnt[i] <= 7'h00;
      end
    end else begin
      act <= next_act;
      cnt <= next_cnt;
    end
  end

  assign sig.irq_act = act;
endmodule : i2csw_irq_filt

// File: i2csw_top_properties.sv
`timescale 1ns/100ps
module i2csw_top_properties import i2csw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic reset_in_n,
  input wire logic [NUM_CHAN-1:0] channel_irq_in_n,
  input wire logic [1:0] addr_sel,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic [NUM_CHAN-1:0] channel_enable
);
  logic [7:0] low_cnt, next_low_cnt, high_cnt, next_high_cnt;
  logic [6:0] scl_cnt, next_scl_cnt;
  logic scl_d;
  // Run lengths of pin levels; saturating so long idles never wrap
  always_comb begin
    next_low_cnt = (&channel_irq_in_n || &low_cnt) ? {8{~&channel_irq_in_n}} & low_cnt
                   : low_cnt + 8'h01;
    next_high_cnt = (!(&channel_irq_in_n) || &high_cnt) ? {8{&channel_irq_in_n}} & high_cnt
                    : high_cnt + 8'h01;
    next_scl_cnt = (scl_d && !scl_in) ? 7'h00 : scl_cnt + {6'h00, ~&scl_cnt};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt <= 8'h00;
      high_cnt <= 8'h00;
      scl_cnt <= 7'h00;
      scl_d <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      scl_cnt <= next_scl_cnt;
      scl_d <= scl_in;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Own SDA edge in the low phase, with the reset pin high now and four cycles back
  sequence s_own_edge;
    $changed(sda_oe_n) && !scl_in && reset_in_n && $past(reset_in_n, 4);
  endsequence
  sequence s_pin_low;
    $fell(reset_in_n) ##1 !reset_in_n [*4];
  endsequence
  property p_od_zero; sda_out == 1'b0 && irq_out == 1'b0; endproperty
  property p_low_rej; $fell(irq_oe_n) |-> low_cnt >= 8'h32; endproperty
  property p_high_rej; $rose(irq_oe_n) |-> high_cnt >= 8'h19; endproperty
  property p_irq_valid; low_cnt == 8'hC8 |-> !irq_oe_n; endproperty
  property p_irq_clear; high_cnt == 8'h64 |-> irq_oe_n; endproperty
  property p_rst_clear; s_pin_low |-> sda_oe_n && channel_enable == 4'h0; endproperty
  property p_sda_hold; s_own_edge |-> scl_cnt >= 7'h0F; endproperty
  property p_sda_valid; s_own_edge |-> scl_cnt <= 7'h30; endproperty
  a_od_zero: assert property (p_od_zero)
    else $error("open-drain value not zero");
  a_low_rej: assert property (p_low_rej)
    else $error("interrupt out on short low pulse");
  a_high_rej: assert property (p_high_rej)
    else $error("interrupt out released on short high pulse");
  a_irq_valid: assert property (p_irq_valid)
    else $error("interrupt out late");
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt out release late");
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset pin did not clear state");
  a_sda_hold: assert property (p_sda_hold)
    else $error("sda changed too soon after scl fall");
  a_sda_valid: assert property (p_sda_valid)
    else $error("sda valid too late after scl fall");
endmodule : i2csw_top_properties

bind i2csw_top i2csw_top_properties i_props (.clk(clk), .rst(rst), .scl_clk(scl_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .reset_in_n(reset_in_n), .channel_irq_in_n(channel_irq_in_n), .addr_sel(addr_sel),
  .irq_out(irq_out), .irq_oe_n(irq_oe_n), .channel_enable(channel_enable));

// File: i2csw_master.sv
`timescale 1ns/100ps
module i2csw_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  logic tick;
  initial begin
    tick = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // 32 ns link timebase, free of any phase tie to the system clock
  always #16 tick = ~tick;
  task automatic half();
    repeat (40) @(posedge tick);
  endtask : half
  task automatic start();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  // Nine bits MSB first; bit zero is the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      half();
      scl = 1'b1;
      half();
      q[i] = sda;
      scl = 1'b0;
    end
  endtask : xfer
  // SCL is left high afterwards so the link clock stands still
  task automatic stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask : stop
endmodule : i2csw_master

// File: tb_i2csw_top.sv
`timescale 1ns/100ps
module tb_i2csw_top import i2csw_pkg::*; ;
  logic clk, rst, reset_in_n, scl, sda_m, sda_out, sda_oe_n, irq_out, irq_oe_n, a;
  logic [3:0] irq_n, ena;
  logic [1:0] asel;
  logic [7:0] adr;
  int err_total, total_checks, k;
  // Wired AND of open-drain parties with a pull-up
  wire sda = sda_m & (sda_oe_n | sda_out);
  always #10 clk = ~clk;
  i2csw_top i_dut (.clk(clk), .rst(rst), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reset_in_n(reset_in_n),
    .channel_irq_in_n(irq_n), .addr_sel(asel), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .channel_enable(ena));
  i2csw_master i_master (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic send(input logic [7:0] d, output logic ack_n);
    logic [8:0] r;
    i_master.xfer({d, 1'b1}, r);
    ack_n = r[0];
  endtask : send
  task automatic wr(input logic [15:0] d, input int n);
    logic b;
    i_master.start();
    send(adr, b);
    chk("addr ack", 8'h00, {7'h00, b});
    for (int i = n - 1; i >= 0; i--) begin
      send(d[8*i +: 8], b);
      chk("data ack", 8'h00, {7'h00, b});
    end
    i_master.stop();
  endtask : wr
  // Master acknowledges every byte but the last, so the device re-sends
  task automatic rd(input logic [7:0] exp, input int n);
    logic [8:0] r;
    logic b;
    i_master.start();
    send({adr[7:1], 1'b1}, b);
    chk("read ack", 8'h00, {7'h00, b});
    for (int i = n - 1; i >= 0; i--) begin
      i_master.xfer((i == 0) ? 9'h1FF : 9'h1FE, r);
      chk("read", exp, r[8:1]);
    end
    i_master.stop();
  endtask : rd
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reset_in_n = 1'b1;
    irq_n = 4'hF;
    asel = 2'b10;
    adr = {DEV_ADDR_HI_DEF, 2'b10, 1'b0};
    cyc(3);
    rst = 1'b0;
    cyc(4);
    chk("enable", 8'h00, {4'h0, ena});
    chk("pins idle", 8'h03, {6'h00, sda_oe_n, irq_oe_n});
    wr(16'h0005, 1);
    chk("enable", 8'h05, {4'h0, ena});
    wr(16'hA30C, 2);
    chk("enable", 8'h0C, {4'h0, ena});
    rd(8'h0C, 1);
    i_master.start();
    send(adr ^ 8'h04, a);
    chk("foreign ack", 8'h01, {7'h00, a});
    i_master.stop();
    $display("test register done");
    for (int c = 0; c < 4; c++) begin
      irq_n = ~(4'h1 << c);
      cyc(45);
      irq_n = 4'hF;
      cyc(60);
      chk("irq out", 8'h01, {7'h00, irq_oe_n});
    end
    irq_n = 4'hB;
    cyc(200);
    chk("irq out", 8'h00, {7'h00, irq_oe_n});
    irq_n = 4'hF;
    cyc(15);
    irq_n = 4'hB;
    cyc(20);
    chk("irq out", 8'h00, {7'h00, irq_oe_n});
    rd(8'h4C, 2);
    irq_n = 4'hF;
    cyc(100);
    chk("irq out", 8'h01, {7'h00, irq_oe_n});
    $display("test interrupt done");
    // Reset pin pulled while the device holds its acknowledge
    fork
      begin
        i_master.start();
        send(adr, a);
        send(8'h0F, a);
        i_master.stop();
      end
      begin
        k = 0;
        while (sda_oe_n !== 1'b0 && k < 3000) begin
          cyc(1);
          k++;
        end
        if (k == 3000) begin
          err_total++;
          finish_test();
        end else begin
          reset_in_n = 1'b0;
          cyc(10);
          chk("sda and enable", 8'h10, {3'h0, sda_oe_n, ena});
          reset_in_n = 1'b1;
        end
      end
    join
    chk("enable", 8'h00, {4'h0, ena});
    wr(16'h0006, 1);
    chk("enable", 8'h06, {4'h0, ena});
    // Pulse lies wholly between two clock edges, so only the catcher sees it
    cyc(1);
    reset_in_n = 1'b0;
    #8;
    reset_in_n = 1'b1;
    cyc(5);
    chk("enable", 8'h00, {4'h0, ena});
    reset_in_n = 1'b0;
    cyc(3);
    reset_in_n = 1'b1;
    wr(16'h0009, 1);
    chk("enable", 8'h09, {4'h0, ena});
    $display("test reset pin done");
    finish_test();
  end
endmodule : tb_i2csw_top
